// ===== vsp_pkg.sv
// Package of constants and carrier types for the video shifter and palette
// Function
// - Legacy mode 00 indexes all sixteen entries of the legacy palette, or of the selected bank if nonzero, mode 01 only 0-3.
// - Legacy palette is 16 entries of 9-bit colour, 3 bits per gun.
// - Legacy monochrome output inverts when bit 0 of entry zero is set.
// - Multi-plane modes draw the border with legacy entry 0, or in extended modes entry 0 of the selected bank.
// - Extended 3-bit mode field decodes to resolution and plane count.
// - Extended palette is 256 entries of 12 bits, 4 bits per gun.
// - Low 4 mode bits pick one of 16 banks for small indices.
// - Mode 111 addresses all 256 extended entries directly, no bank.
// - Two-colour mode shows pixel 0 with entry 254, pixel 1 with 255.
// - Two-colour mode swaps colours when an entry-zero inversion bit is set.
// - Grey mode drives all guns with green high nibble, blue low nibble.
// - Memory is 1,2,4 or 8 interleaved 16-bit planes; 32000/153600 bytes.
// - Top byte of the 32-bit display address is always zero.
// - Base registers are copied into the address counter each frame start.
// - Address counter advances as each piece of the buffer is read.
// - Screen data is fetched into the buffer 64 bits at a time.
// - One bit per plane forms the index; plane 0 is the LSB.
package vsp_pkg;
   localparam int VSP_LEG_BUF_BYTES = 32000;
   localparam int VSP_EXT_BUF_BYTES = 153600;
   localparam int VSP_FETCH_BYTES = 8;
   localparam int VSP_LEG_FETCHES = VSP_LEG_BUF_BYTES / VSP_FETCH_BYTES;
   localparam int VSP_EXT_FETCHES = VSP_EXT_BUF_BYTES / VSP_FETCH_BYTES;
   localparam int VSP_ALIGN_BITS = 3;
   localparam int VSP_FIFO_DEPTH = 32;
   localparam int VSP_FETCH_W = 64;
   localparam int VSP_PLANE_W = 16;
   localparam int VSP_LEG_ENTRIES = 16;
   localparam int VSP_EXT_ENTRIES = 256;
   localparam logic [7:0] VSP_DUO_ZERO_ENTRY = 8'hfe;
   localparam int VSP_MONO_INV_BIT = 0;
   localparam int VSP_DUO_INV_BIT = 1;
   localparam int VSP_PIPE_LATENCY = 2;

   typedef enum logic [1:0] {
      VSP_LM_320X4 = 2'b00,
      VSP_LM_640X2 = 2'b01,
      VSP_LM_MONO = 2'b10
   } vsp_leg_mode_e;

   typedef enum logic [2:0] {
      VSP_XM_320X4 = 3'b000,
      VSP_XM_640X2 = 3'b001,
      VSP_XM_DUO = 3'b010,
      VSP_XM_640X480 = 3'b100,
      VSP_XM_MONO = 3'b110,
      VSP_XM_256 = 3'b111
   } vsp_ext_mode_e;

   typedef struct packed {
      logic ext_sel;
      logic [1:0] leg_mode;
      logic [2:0] ext_mode;
      logic [3:0] palette_bank_select;
      logic eight_bit_grey_mode;
   } vsp_mode_s;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } vsp_rgb_s;
endpackage

// ===== vsp_video_shifter_palette.sv
// Fetch FIFO and the video shifter with colour lookup table path
`timescale 1ns/10ps
`default_nettype none

module vsp_fifo #(
   parameter int W = 64,
   parameter int D = 32
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_flush,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next, cnt;
   logic push, pop;

   always_comb begin
      cnt = wr_reg - rd_reg;
      o_in_ready = (cnt != (AW+1)'(D));
      o_out_valid = (cnt != '0);
      o_out_data = mem[rd_reg[AW-1:0]];
      push = i_in_valid && o_in_ready;
      pop = o_out_valid && i_out_ready;
      wr_next = i_flush ? '0 : wr_reg + (AW+1)'(push);
      rd_next = i_flush ? '0 : rd_reg + (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage needs no reset; empty flags keep stale words unseen
   always_ff @(posedge i_clk) begin
      if (push && !i_flush) begin
         mem[wr_reg[AW-1:0]] <= i_in_data;
      end
   end
endmodule

module vsp_video_shifter_palette
   import vsp_pkg::*;
#(
   parameter int P_LEG_FETCHES = VSP_LEG_FETCHES,
   parameter int P_EXT_FETCHES = VSP_EXT_FETCHES,
   parameter int P_FIFO_DEPTH = VSP_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Timing from the sync generator
   input wire logic i_frame_start,
   input wire logic i_pixel_en,
   input wire logic i_display_active,
   // Configuration
   input wire vsp_mode_s i_mode,
   input wire logic [7:0] i_base_high,
   input wire logic [7:0] i_base_mid,
   input wire logic [7:0] i_base_low,
   // Palette writes
   input wire logic i_leg_pal_we,
   input wire logic [3:0] i_leg_pal_addr,
   input wire logic [8:0] i_leg_pal_data,
   input wire logic i_ext_pal_we,
   input wire logic [7:0] i_ext_pal_addr,
   input wire logic [11:0] i_ext_pal_data,
   // Display memory read port
   output logic o_mem_req,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [VSP_FETCH_W-1:0] i_mem_data,
   // DAC levels
   output vsp_rgb_s o_rgb
);
   typedef enum logic [2:0] {
      VSP_K_LEG = 3'b000,
      VSP_K_BANK = 3'b001,
      VSP_K_FULL = 3'b010,
      VSP_K_DUO = 3'b011,
      VSP_K_MONO = 3'b100
   } vsp_kind_e;

   function automatic logic [3:0] plane_count(input vsp_mode_s m);
      logic [3:0] p;
      p = 4'h1;
      if (!m.ext_sel) begin
         case (m.leg_mode)
            VSP_LM_320X4: p = 4'h4;
            VSP_LM_640X2: p = 4'h2;
            default: p = 4'h1;
         endcase
      end else begin
         case (m.ext_mode)
            VSP_XM_320X4, VSP_XM_640X480: p = 4'h4;
            VSP_XM_640X2: p = 4'h2;
            VSP_XM_256: p = 4'h8;
            default: p = 4'h1;
         endcase
      end
      return p;
   endfunction

   function automatic vsp_kind_e mode_kind(input vsp_mode_s m);
      vsp_kind_e k;
      k = VSP_K_BANK;
      if (!m.ext_sel) begin
         k = (m.leg_mode == VSP_LM_MONO) ? VSP_K_MONO : VSP_K_LEG;
      end else begin
         case (m.ext_mode)
            VSP_XM_256: k = VSP_K_FULL;
            VSP_XM_DUO: k = VSP_K_DUO;
            VSP_XM_MONO: k = VSP_K_MONO;
            default: k = VSP_K_BANK;
         endcase
      end
      return k;
   endfunction

   // Widen a 3-bit legacy gun to 4 bits by repeating its top bit
   function automatic logic [11:0] leg_to_12(input logic [8:0] e);
      return {e[8:6], e[8], e[5:3], e[5], e[2:0], e[2]};
   endfunction

   logic [8:0] leg_pal [VSP_LEG_ENTRIES];
   logic [11:0] ext_pal [VSP_EXT_ENTRIES];

   vsp_mode_s mode_reg, mode_next;
   logic [3:0] planes;
   vsp_kind_e kind;
   logic [23:0] addr_reg, addr_next;
   logic [14:0] left_reg, left_next;
   logic req_reg, req_next;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [VSP_FETCH_W-1:0] fifo_data;
   logic [7:0][15:0] buf_reg, buf_next, pl_reg, pl_next;
   logic [3:0] avail_reg, avail_next, cnt_reg, cnt_next;
   logic grp_reg, grp_next;
   logic [7:0] idx_reg, idx_next;
   logic vis_reg, vis_next;
   vsp_rgb_s rgb_next;
   logic step, inv_mono, inv_duo;
   logic [11:0] col;

   assign planes = plane_count(mode_reg);
   assign kind = mode_kind(mode_reg);
   assign step = i_pixel_en && i_display_active;

   vsp_fifo #(.W(VSP_FETCH_W), .D(P_FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_flush(i_frame_start),
      .i_in_valid(req_reg && i_mem_ack),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_mem_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_data)
   );

   // Fetch side: one outstanding request, only while the FIFO has room
   always_comb begin
      mode_next = mode_reg;
      addr_next = addr_reg;
      left_next = left_reg;
      req_next = req_reg;
      if (i_frame_start) begin
         mode_next = i_mode;
         addr_next = {i_base_high, i_base_mid,
            i_base_low[7:VSP_ALIGN_BITS], 3'h0};
         left_next = i_mode.ext_sel ? 15'(P_EXT_FETCHES)
            : 15'(P_LEG_FETCHES);
         req_next = 1'b0;
      end else if (req_reg) begin
         if (i_mem_ack) begin
            req_next = 1'b0;
            addr_next = addr_reg + 24'(VSP_FETCH_BYTES);
            left_next = left_reg - 15'h1;
         end
      end else if (left_reg != 15'h0 && fifo_in_ready) begin
         req_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_reg <= '0;
         addr_reg <= 24'h000000;
         left_reg <= 15'h0000;
         req_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         addr_reg <= addr_next;
         left_reg <= left_next;
         req_reg <= req_next;
      end
   end

   // Shifter: eight-word staging buffer feeds a group of plane words
   assign fifo_pop = fifo_out_valid && (avail_reg <= 4'h4) && !i_frame_start;

   always_comb begin
      buf_next = buf_reg;
      avail_next = avail_reg;
      pl_next = pl_reg;
      cnt_next = cnt_reg;
      grp_next = grp_reg;
      idx_next = idx_reg;
      vis_next = vis_reg;
      for (int p = 0; p < 8; p++) begin
         idx_next[p] = grp_reg && pl_reg[p][15];
      end
      if (i_frame_start) begin
         buf_next = '0;
         avail_next = 4'h0;
         pl_next = '0;
         cnt_next = 4'h0;
         grp_next = 1'b0;
      end else begin
         if (step && grp_reg) begin
            for (int p = 0; p < 8; p++) begin
               pl_next[p] = {pl_reg[p][14:0], 1'b0};
            end
            cnt_next = cnt_reg + 4'h1;
            grp_next = (cnt_reg != 4'hf);
         end
         if (!grp_next && avail_reg >= planes) begin
            for (int p = 0; p < 8; p++) begin
               // Unused planes stay zero so small modes keep small indices
               pl_next[p] = (p < planes) ? buf_reg[p] : 16'h0000;
               buf_next[p] = (p + planes < 8) ? buf_reg[p + planes] : 16'h0;
            end
            avail_next = avail_reg - planes;
            grp_next = 1'b1;
            cnt_next = 4'h0;
         end
         if (fifo_pop) begin
            // First word in memory sits in the top lane of the fetch
            for (int k = 0; k < 4; k++) begin
               buf_next[avail_next + 4'(k)] =
                  fifo_data[VSP_FETCH_W-1-VSP_PLANE_W*k -: VSP_PLANE_W];
            end
            avail_next = avail_next + 4'h4;
         end
      end
      if (i_pixel_en) begin
         vis_next = i_display_active;
         if (!i_display_active) begin
            idx_next = 8'h00;
         end
      end else begin
         idx_next = idx_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         buf_reg <= '0;
         avail_reg <= 4'h0;
         pl_reg <= '0;
         cnt_reg <= 4'h0;
         grp_reg <= 1'b0;
         idx_reg <= 8'h00;
         vis_reg <= 1'b0;
      end else begin
         buf_reg <= buf_next;
         avail_reg <= avail_next;
         pl_reg <= pl_next;
         cnt_reg <= cnt_next;
         grp_reg <= grp_next;
         idx_reg <= idx_next;
         vis_reg <= vis_next;
      end
   end

   // Palettes
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < VSP_LEG_ENTRIES; i++) begin
            leg_pal[i] <= 9'h000;
         end
         for (int i = 0; i < VSP_EXT_ENTRIES; i++) begin
            ext_pal[i] <= 12'h000;
         end
      end else begin
         if (i_leg_pal_we) begin
            leg_pal[i_leg_pal_addr] <= i_leg_pal_data;
         end
         if (i_ext_pal_we) begin
            ext_pal[i_ext_pal_addr] <= i_ext_pal_data;
         end
      end
   end

   // Lookup stage: second and last pipeline register
   assign inv_mono = leg_pal[0][VSP_MONO_INV_BIT];
   assign inv_duo = leg_pal[0][VSP_DUO_INV_BIT]
      | ext_pal[0][VSP_DUO_INV_BIT];

   always_comb begin
      col = 12'h000;
      if (!vis_reg) begin
         if (planes != 4'h1) begin
            col = mode_reg.ext_sel
               ? ext_pal[{mode_reg.palette_bank_select, 4'h0}]
               : leg_to_12(leg_pal[0]);
         end
      end else begin
         case (kind)
            VSP_K_LEG: begin
               // Bank 0 is the legacy palette itself; others borrow banks
               if (mode_reg.palette_bank_select == 4'h0) begin
                  col = leg_to_12(leg_pal[idx_reg[3:0]]);
               end else begin
                  col = ext_pal[{mode_reg.palette_bank_select,
                     idx_reg[3:0]}];
               end
            end
            VSP_K_BANK: col = ext_pal[{mode_reg.palette_bank_select,
               idx_reg[3:0]}];
            VSP_K_FULL: col = ext_pal[idx_reg];
            VSP_K_DUO: col = ext_pal[{VSP_DUO_ZERO_ENTRY[7:1],
               idx_reg[0] ^ inv_duo}];
            VSP_K_MONO: col = (idx_reg[0] ^ inv_mono) ? 12'hfff
               : 12'h000;
            default: col = 12'h000;
         endcase
      end
      if (mode_reg.eight_bit_grey_mode) begin
         rgb_next.red = col[7:0];
         rgb_next.green = col[7:0];
         rgb_next.blue = col[7:0];
      end else begin
         rgb_next.red = {col[11:8], col[11:8]};
         rgb_next.green = {col[7:4], col[7:4]};
         rgb_next.blue = {col[3:0], col[3:0]};
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rgb <= '0;
         o_mem_req <= 1'b0;
         o_mem_addr <= 32'h00000000;
      end else begin
         if (i_pixel_en) begin
            o_rgb <= rgb_next;
         end
         o_mem_req <= req_next;
         o_mem_addr <= {8'h00, addr_next};
      end
   end
endmodule

`default_nettype wire

// ===== vsp_checker_assertions.sv
// Port assertions for the video shifter and palette block
`timescale 1ns/10ps
`default_nettype none
module vsp_checker
   import vsp_pkg::*;
#(
   parameter int P_LEG_FETCHES = VSP_LEG_FETCHES,
   parameter int P_EXT_FETCHES = VSP_EXT_FETCHES
) (
   // Clock, reset and timing
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_frame_start,
   input wire logic i_pixel_en,
   // Configuration, memory port and output
   input wire vsp_mode_s i_mode,
   input wire logic [7:0] i_base_high,
   input wire logic [7:0] i_base_mid,
   input wire logic [7:0] i_base_low,
   input wire logic o_mem_req,
   input wire logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire vsp_rgb_s o_rgb
);
   logic [31:0] addr_reg;
   int fetch_reg;
   logic [1:0] pix_reg;
   vsp_mode_s mode_reg;
   logic mono;
   logic ready;
   assign mono = mode_reg.ext_sel ? mode_reg.ext_mode == 3'h6
      : mode_reg.leg_mode == 2'h2;
   // Old frame pixels stay on the output until two pixel steps have passed
   assign ready = pix_reg == 2'h2;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         addr_reg <= '0;
         fetch_reg <= 0;
         pix_reg <= 2'h0;
         mode_reg <= '0;
      end else if (i_frame_start) begin
         addr_reg <= {8'h00, i_base_high, i_base_mid, i_base_low & 8'hf8};
         fetch_reg <= 0;
         pix_reg <= 2'h0;
         mode_reg <= i_mode;
      end else begin
         if (o_mem_req && i_mem_ack) begin
            addr_reg <= addr_reg + 32'h8;
            fetch_reg <= fetch_reg + 1;
         end
         if (i_pixel_en && !ready) begin
            pix_reg <= pix_reg + 2'h1;
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   addr_top_a: assert property (
      o_mem_req |-> o_mem_addr[31:24] == 8'h00 && o_mem_addr[2:0] == 3'h0)
      else $error("fetch address out of range");
   addr_seq_a: assert property (
      o_mem_req |-> o_mem_addr == addr_reg)
      else $error("fetch address out of sequence");
   req_hold_a: assert property (
      o_mem_req && !i_mem_ack && !i_frame_start |=>
      o_mem_req && $stable(o_mem_addr)) else $error("request not held");
   req_gap_a: assert property (
      o_mem_req && i_mem_ack && !i_frame_start |=> !o_mem_req)
      else $error("request not dropped after answer");
   fetch_cap_a: assert property (
      o_mem_req |-> fetch_reg <
      (mode_reg.ext_sel ? P_EXT_FETCHES : P_LEG_FETCHES))
      else $error("too many fetches in one frame");
   rgb_hold_a: assert property (
      !i_pixel_en |=> $stable(o_rgb)) else $error("output moved off step");
   grey_level_a: assert property (
      ready && mode_reg.eight_bit_grey_mode |->
      o_rgb.red == o_rgb.green && o_rgb.green == o_rgb.blue)
      else $error("grey guns differ");
   mono_level_a: assert property (
      ready && mono && !mode_reg.eight_bit_grey_mode |->
      o_rgb == 24'hffffff || o_rgb == 24'h000000)
      else $error("monochrome level not black or white");
   cover property (o_mem_req && i_mem_ack);
   cover property (ready && mode_reg.eight_bit_grey_mode);
   cover property (ready && mono);
endmodule
bind vsp_video_shifter_palette vsp_checker #(
   .P_LEG_FETCHES(P_LEG_FETCHES), .P_EXT_FETCHES(P_EXT_FETCHES)
) u_vsp_checker (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_frame_start(i_frame_start),
   .i_pixel_en(i_pixel_en), .i_mode(i_mode), .i_base_high(i_base_high),
   .i_base_mid(i_base_mid), .i_base_low(i_base_low), .o_mem_req(o_mem_req),
   .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .o_rgb(o_rgb)
);
`default_nettype wire

// ===== vsp_mem_model.sv
// Display memory model answering the block's fetch port
`timescale 1ns/10ps
`default_nettype none
module vsp_mem_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Fetch port
   input wire logic i_req,
   output logic o_ack,
   output logic [63:0] o_data,
   // Word served and answer delay
   input wire logic [63:0] i_fill,
   input wire logic [3:0] i_delay
);
   logic [3:0] wait_reg;
   logic go;
   assign go = i_req && !o_ack && wait_reg >= i_delay;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_reg <= 4'h0;
         o_ack <= 1'b0;
         o_data <= 64'h0;
      end else begin
         o_ack <= go;
         wait_reg <= (i_req && !o_ack && !go) ? wait_reg + 4'h1 : 4'h0;
         // Outside the answer the bus toggles, so no stale word can pass
         o_data <= go ? i_fill : ~o_data;
      end
   end
endmodule
`default_nettype wire

// ===== vsp_video_shifter_palette_tb_top.sv
// Self-checking bench for the video shifter and palette block
`timescale 1ns/10ps
`default_nettype none
module vsp_video_shifter_palette_tb_top
   import vsp_pkg::*;
   ;
   localparam logic [31:0] BASE = 32'h0012_3458; // Aligned start
   localparam logic [63:0] F4 = 64'hffff_0000_ffff_0000;
   localparam logic [63:0] F1 = 64'hffff_ffff_ffff_ffff;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic frame_go = 1'b0;
   logic pix_en = 1'b0;
   logic active = 1'b0;
   vsp_mode_s mode = '0;
   logic leg_we = 1'b0;
   logic ext_we = 1'b0;
   logic [7:0] pal_addr = 8'h00;
   logic [8:0] leg_data = 9'h000;
   logic [11:0] ext_data = 12'h000;
   logic mem_req;
   logic [31:0] mem_addr;
   logic mem_ack;
   logic [63:0] mem_data;
   vsp_rgb_s rgb;
   logic [63:0] fill = 64'h0;
   logic [3:0] delay = 4'h2;
   int ack_cnt = 0;
   int bad_count = 0;
   int samples_checked = 0;
   // Short frames of 48 fetches let the 32-word buffer fill and drain
   vsp_video_shifter_palette #(
      .P_LEG_FETCHES(48), .P_EXT_FETCHES(48), .P_FIFO_DEPTH(32)
   ) u_vsp_video_shifter_palette (
      .i_clk(clk), .i_reset_n(rst_n), .i_frame_start(frame_go),
      .i_pixel_en(pix_en), .i_display_active(active), .i_mode(mode),
      .i_base_high(BASE[23:16]), .i_base_mid(BASE[15:8]),
      .i_base_low(BASE[7:0]), .i_leg_pal_we(leg_we),
      .i_leg_pal_addr(pal_addr[3:0]), .i_leg_pal_data(leg_data),
      .i_ext_pal_we(ext_we), .i_ext_pal_addr(pal_addr),
      .i_ext_pal_data(ext_data), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
      .i_mem_ack(mem_ack), .i_mem_data(mem_data), .o_rgb(rgb)
   );
   vsp_mem_model u_vsp_mem_model (
      .i_clk(clk), .i_reset_n(rst_n), .i_req(mem_req), .o_ack(mem_ack),
      .o_data(mem_data), .i_fill(fill), .i_delay(delay)
   );
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (frame_go) begin
         ack_cnt <= 0;
      end else if (mem_req && mem_ack) begin
         ack_cnt <= ack_cnt + 1;
      end
   end
   function automatic vsp_mode_s md(input int x, l, e, b, g);
      return {1'(x), 2'(l), 3'(e), 4'(b), 1'(g)};
   endfunction
   function automatic logic [11:0] xv(input int a);
      return {4'(a) ^ 4'h5, 4'(a >> 4), 4'(a) ^ 4'h8};
   endfunction
   function automatic logic [8:0] lv(input int a);
      return {3'(a), ~3'(a), 1'(a >> 3), 2'(a)};
   endfunction
   function automatic logic [7:0] g3(input logic [2:0] c);
      return {c, c[2], c, c[2]};
   endfunction
   function automatic vsp_rgb_s lr(input int a);
      return {g3(3'(a)), g3(~3'(a)), g3({1'(a >> 3), 2'(a)})};
   endfunction
   function automatic vsp_rgb_s xr(input int a);
      return {{2{4'(a) ^ 4'h5}}, {2{4'(a >> 4)}}, {2{4'(a) ^ 4'h8}}};
   endfunction
   function automatic vsp_rgb_s gr(input int a);
      return {3{4'(a >> 4), 4'(a) ^ 4'h8}};
   endfunction
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wp(input int a, input logic [8:0] ld, input logic [11:0] xd);
      @(posedge clk);
      leg_we <= a < 16;
      ext_we <= 1'b1;
      pal_addr <= 8'(a);
      leg_data <= ld;
      ext_data <= xd;
      @(posedge clk);
      leg_we <= 1'b0;
      ext_we <= 1'b0;
   endtask
   task automatic run(input vsp_mode_s m, input logic [63:0] f,
                      input logic act, input vsp_rgb_s e);
      @(posedge clk);
      fill <= f;
      @(posedge clk);
      mode <= m;
      frame_go <= 1'b1;
      @(posedge clk);
      frame_go <= 1'b0;
      // A mode change in mid-frame must not reach this frame
      mode <= '0;
      // The request is raised one edge after the frame start reloads it
      @(posedge clk);
      #1 cmp({mem_req, mem_addr}, {1'b1, BASE});
      repeat (40) @(posedge clk);
      active <= act;
      pix_en <= 1'b1;
      repeat (6) @(posedge clk);
      pix_en <= 1'b0;
      @(posedge clk);
      #1 cmp(rgb, e);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1 cmp({mem_req, rgb}, 64'h0);
      for (int i = 0; i < 256; i++) wp(i, lv(i), xv(i));
      run(md(0, 0, 0, 0, 0), F4, 1'b1, lr(5));
      run(md(0, 1, 0, 0, 0), F4, 1'b1, lr(1));
      run(md(0, 0, 0, 0, 0), F4, 1'b0, lr(0));
      run(md(0, 2, 0, 0, 0), F1, 1'b1, 24'hffffff);
      run(md(0, 0, 0, 3, 0), F4, 1'b1, xr(8'h35));
      run(md(1, 0, 0, 3, 0), F4, 1'b1, xr(8'h35));
      run(md(1, 0, 0, 3, 0), F4, 1'b0, xr(8'h30));
      run(md(1, 0, 1, 3, 0), F4, 1'b1, xr(8'h31));
      run(md(1, 0, 4, 3, 0), F4, 1'b1, xr(8'h35));
      run(md(1, 0, 7, 3, 0), F4, 1'b1, xr(8'h55));
      run(md(1, 0, 2, 3, 0), F1, 1'b1, xr(8'hff));
      run(md(1, 0, 2, 3, 0), 64'h0, 1'b1, xr(8'hfe));
      run(md(1, 0, 6, 0, 0), F1, 1'b1, 24'hffffff);
      run(md(1, 0, 3, 3, 0), F1, 1'b1, xr(8'h31));
      run(md(1, 0, 0, 3, 1), F4, 1'b1, gr(8'h35));
      @(posedge clk);
      delay <= 4'h0;
      frame_go <= 1'b1;
      @(posedge clk);
      frame_go <= 1'b0;
      repeat (300) @(posedge clk);
      #1 cmp({mem_req, 1'(ack_cnt > 31 && ack_cnt < 48)}, 64'h1);
      delay <= 4'h3;
      pix_en <= 1'b1;
      active <= 1'b1;
      repeat (900) @(posedge clk);
      pix_en <= 1'b0;
      #1 cmp({mem_req, 32'(ack_cnt), rgb}, {1'b0, 32'd48, lr(0)});
      wp(0, lv(0) | 9'h001, xv(0));
      run(md(0, 2, 0, 0, 0), F1, 1'b1, 24'h000000);
      wp(0, lv(0) | 9'h002, xv(0));
      run(md(1, 0, 2, 3, 0), F1, 1'b1, xr(8'hfe));
      wp(0, lv(0), xv(0) | 12'h002);
      run(md(1, 0, 2, 3, 0), 64'h0, 1'b1, xr(8'hff));
      complete_run();
   end
endmodule
`default_nettype wire
